// File: ppc_ahb_slave.sv
// ahb-lite slave front end: zero wait states, always okay
// assumes a single master, single word transfers, one clock
`timescale 1ns/1ps
module ppc_ahb_slave #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // ahb-lite
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // register side
    output logic [5:0] rd_idx,
    input wire logic [15:0] rd_data,
    output logic wr_en,
    output logic [5:0] wr_idx,
    output logic [15:0] wr_data
);
    logic acc; // address phase taken this cycle
    logic wr_pend_q, wr_pend_d; // write data phase pending
    logic [5:0] wr_idx_q, wr_idx_d;
    logic [31:0] hrdata_d;

    // decode the address phase; nonseq or seq both count
    always_comb begin
        acc = hsel && htrans[1] && hready;
        rd_idx = 6'(haddr[ADDR_W-1:2]);
        wr_pend_d = acc && hwrite;
        wr_idx_d = acc ? rd_idx : wr_idx_q;
        // read data captured at the address edge so it stands in the data phase
        hrdata_d = (acc && !hwrite) ? {16'h0000, rd_data} : 32'h0000_0000;
    end

    // write strobe sits in the data phase, when hwdata is valid
    always_comb begin
        wr_en = wr_pend_q;
        wr_idx = wr_idx_q;
        wr_data = hwdata[15:0];
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 6'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_idx_q <= wr_idx_d;
            hrdata <= hrdata_d;
            hreadyout <= 1'b1; // never stalls
            hresp <= 1'b0; // unmapped reads zero, writes ignored
        end
    end
endmodule

// File: ppc_led_blank.sv
// led output stage: forces each led pin high while blanking
// assumes led patterns come from logic on the same clock
`timescale 1ns/1ps
module ppc_led_blank #(
    parameter int N = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // control
    input wire logic blank,
    input wire logic [N-1:0] led_in,
    // pins, active low leds
    output logic [N-1:0] led_out
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_led
            logic nxt;
            // high turns the led off
            always_comb begin
                nxt = blank ? 1'b1 : led_in[i];
            end
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    led_out[i] <= 1'b1; // dark through reset
                end else begin
                    led_out[i] <= nxt;
                end
            end
        end
    endgenerate
endmodule

// File: ppc_pkg.sv
// types shared by the port phy control block
// assumes the constants header is included where offsets are needed
package ppc_pkg;
    // restart sequencer states
    typedef enum logic [1:0] {
        PPC_AN_IDLE = 2'b00,
        PPC_AN_KICK = 2'b01,
        PPC_AN_WAIT = 2'b10
    } ppc_an_e;
    // one register word
    typedef logic [15:0] ppc_word_t;
endpackage

// File: ppc_port_phy_ctrl.sv
// second port phy control register with ahb-lite access and registered control outputs
// assumes negotiation, phy and led logic run on ref_clk, so their signals need no synchroniser
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "ppc_regs.svh"
module ppc_port_phy_ctrl #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // negotiation results
    input wire logic an_done,
    input wire logic an_failed,
    input wire logic an_speed_100,
    input wire logic an_full_duplex,
    // led patterns from led logic
    input wire logic [3:0] led_state,
    // led pins
    output logic second_port_led_out_0,
    output logic second_port_led_out_1,
    output logic second_port_led_out_2,
    output logic second_port_led_out_3,
    // phy controls
    output logic tx_disable,
    output logic phy_power_down,
    output logic auto_mdix_en,
    output logic force_mdix,
    output logic far_end_loopback,
    output logic phy_speed_100,
    output logic phy_full_duplex,
    // negotiation controls
    output logic an_enable,
    output logic an_restart,
    output logic adv_pause,
    output logic adv_100_full,
    output logic adv_100_half,
    output logic adv_10_full,
    output logic adv_10_half
);
    // bus side
    logic [5:0] rd_idx; // index in the address phase
    logic [15:0] rd_data; // value offered to the read
    logic wr_en; // data phase write strobe
    logic [5:0] wr_idx;
    logic [15:0] wr_data;
    logic wr_ctrl; // write hits the control register
    // register state
    ppc_pkg::ppc_word_t ctrl_q, ctrl_d;
    ppc_pkg::ppc_an_e an_q, an_d;
    logic [3:0] led_pins;
    // next values of the registered outputs
    logic tx_dis_d, pwr_d, amdix_d, fmdix_d, lb_d, spd_d, dup_d, ane_d, rst_d;
    logic [4:0] adv_d;

    // hsize is not decoded: only whole words are supported

    // reads the register at a given index; the control word shows its next value so
    // a read right behind a write sees the new data
    function automatic logic [15:0] read_reg(input logic [5:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        case (idx)
            `PPC_IDX_CTRL: v = ctrl_d;
            `PPC_IDX_STAT: begin
                v[`PPC_S_BUSY] = (an_q != ppc_pkg::PPC_AN_IDLE);
                v[`PPC_S_SPEED] = phy_speed_100;
                v[`PPC_S_DUPLEX] = phy_full_duplex;
                v[`PPC_S_FMDIX] = force_mdix;
                v[`PPC_S_AMDIX] = auto_mdix_en;
            end
            default: v = 16'h0000; // unmapped reads zero
        endcase
        return v;
    endfunction

    // bus front end
    ppc_ahb_slave #(.ADDR_W(ADDR_W)) u_bus (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .rd_idx(rd_idx),
        .rd_data(rd_data),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_data(wr_data)
    );

    // read mux
    always_comb begin
        rd_data = read_reg(rd_idx);
    end

    // control word: reserved bit 12 is masked so it stays zero
    always_comb begin
        wr_ctrl = wr_en && (wr_idx == `PPC_IDX_CTRL);
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = wr_data & `PPC_CTRL_WMASK;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `PPC_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // a control write that asks for a restart; shared by the sequencer and its checks
    function automatic logic restart_req(input logic wr, input logic [15:0] data);
        return wr && data[`PPC_B_AN_RESTART] && data[`PPC_B_AN_EN];
    endfunction

    // restart sequencer: a write of one to bit 13 kicks one restart pulse, then
    // waits for the negotiation to finish; a restart with negotiation off is dropped
    always_comb begin
        an_d = an_q;
        case (an_q)
            ppc_pkg::PPC_AN_IDLE: begin
                if (restart_req(wr_ctrl, wr_data)) begin
                    an_d = ppc_pkg::PPC_AN_KICK;
                end
            end
            ppc_pkg::PPC_AN_KICK: begin
                // a restart write landing on the pulse stretches it rather than being lost
                if (restart_req(wr_ctrl, wr_data)) begin
                    an_d = ppc_pkg::PPC_AN_KICK;
                end else begin
                    an_d = ppc_pkg::PPC_AN_WAIT;
                end
            end
            ppc_pkg::PPC_AN_WAIT: begin
                // a fresh restart write re-kicks; done, failure or disable end the wait
                if (restart_req(wr_ctrl, wr_data)) begin
                    an_d = ppc_pkg::PPC_AN_KICK;
                end else if (an_done || an_failed || !ctrl_q[`PPC_B_AN_EN]) begin
                    an_d = ppc_pkg::PPC_AN_IDLE;
                end
            end
            default: an_d = ppc_pkg::PPC_AN_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            an_q <= ppc_pkg::PPC_AN_IDLE;
        end else begin
            an_q <= an_d;
        end
    end

    // output decode from the next control word, so pins move with the register
    always_comb begin
        tx_dis_d = ctrl_d[`PPC_B_TX_DIS];
        pwr_d = ctrl_d[`PPC_B_PWR_DOWN];
        amdix_d = !ctrl_d[`PPC_B_MDIX_DIS];
        fmdix_d = ctrl_d[`PPC_B_MDIX_DIS] && ctrl_d[`PPC_B_FORCE_MDIX];
        lb_d = ctrl_d[`PPC_B_FAR_LB];
        ane_d = ctrl_d[`PPC_B_AN_EN];
        rst_d = (an_d == ppc_pkg::PPC_AN_KICK);
        // negotiated speed while negotiation is on; negotiated duplex only while it is on and has not failed
        spd_d = ane_d ? an_speed_100 : ctrl_d[`PPC_B_SPEED];
        dup_d = (ane_d && !an_failed) ? an_full_duplex : ctrl_d[`PPC_B_DUPLEX];
        adv_d = ctrl_d[4:0];
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx_disable <= 1'b0;
            phy_power_down <= 1'b0;
            auto_mdix_en <= 1'b1;
            force_mdix <= 1'b0;
            far_end_loopback <= 1'b0;
            an_enable <= 1'b1;
            an_restart <= 1'b0;
            phy_speed_100 <= 1'b0;
            phy_full_duplex <= 1'b0;
            {adv_pause, adv_100_full, adv_100_half, adv_10_full, adv_10_half} <= 5'h1f;
        end else begin
            tx_disable <= tx_dis_d;
            phy_power_down <= pwr_d;
            auto_mdix_en <= amdix_d;
            force_mdix <= fmdix_d;
            far_end_loopback <= lb_d;
            an_enable <= ane_d;
            an_restart <= rst_d;
            phy_speed_100 <= spd_d;
            phy_full_duplex <= dup_d;
            {adv_pause, adv_100_full, adv_100_half, adv_10_full, adv_10_half} <= adv_d;
        end
    end

    // led pins, blanked high from the next control word
    ppc_led_blank #(.N(4)) u_led (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .blank(ctrl_d[`PPC_B_LED_OFF]),
        .led_in(led_state),
        .led_out(led_pins)
    );

    always_comb begin
        second_port_led_out_0 = led_pins[0];
        second_port_led_out_1 = led_pins[1];
        second_port_led_out_2 = led_pins[2];
        second_port_led_out_3 = led_pins[3];
    end

    // checks on the registered outputs against the stored word
    // the led pass-through and negotiated speed and duplex checks skip the first edge after reset, where the flops still show reset values
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_led_blank_high: assert property (ctrl_q[`PPC_B_LED_OFF] |-> (led_pins == 4'hf))
        else $error("leds not dark while blanked");
    a_led_pass_thru: assert property (($past(nrst) && !ctrl_q[`PPC_B_LED_OFF])
        |-> (led_pins == $past(led_state)))
        else $error("led pattern not passed through");
    a_tx_disable_follows: assert property (tx_disable == ctrl_q[`PPC_B_TX_DIS])
        else $error("transmitter disable mismatch");
    // restart sequencer, then power down, reserved bit, crossover and loopback
    a_restart_one_pulse: assert property (restart_req(wr_ctrl, wr_data) |=> an_restart)
        else $error("restart write gave no pulse");
    a_restart_ends: assert property ((an_restart && !restart_req(wr_ctrl, wr_data)) |=> !an_restart)
        else $error("restart pulse too long");
    a_restart_needs_write: assert property ($rose(an_restart) |-> $past(restart_req(wr_ctrl, wr_data)))
        else $error("restart pulse without a write");
    a_restart_not_disabled: assert property ((wr_ctrl && !wr_data[`PPC_B_AN_EN]) |=> !an_restart)
        else $error("restart while negotiation off");
    a_busy_clears: assert property ((an_q == ppc_pkg::PPC_AN_WAIT) && an_done
        && !restart_req(wr_ctrl, wr_data) |=> (an_q == ppc_pkg::PPC_AN_IDLE))
        else $error("restart busy not cleared on done");
    a_power_down_rsvd: assert property ((phy_power_down == ctrl_q[11]) && !ctrl_q[12])
        else $error("power down or reserved bit wrong");
    a_auto_mdix_en: assert property (auto_mdix_en != ctrl_q[`PPC_B_MDIX_DIS])
        else $error("auto crossover enable wrong");
    a_force_mdix_gate: assert property (force_mdix == (ctrl_q[10] && ctrl_q[9]))
        else $error("forced crossover wrong");
    a_far_loopback: assert property (far_end_loopback == ctrl_q[`PPC_B_FAR_LB])
        else $error("loopback control wrong");
    // negotiation enable, forced and negotiated speed and duplex, advertised abilities, control write
    a_an_enable_follows: assert property (an_enable == ctrl_q[`PPC_B_AN_EN])
        else $error("negotiation enable mismatch");
    a_forced_speed: assert property (!ctrl_q[7] |-> (phy_speed_100 == ctrl_q[6] && !an_enable))
        else $error("forced speed not applied");
    a_forced_duplex: assert property ((!ctrl_q[7] || $past(an_failed)) |-> phy_full_duplex == ctrl_q[5])
        else $error("forced duplex not applied");
    a_advert_bits: assert property ({adv_pause, adv_100_full, adv_100_half, adv_10_full, adv_10_half}
        == ctrl_q[4:0])
        else $error("advertised abilities mismatch");
    a_neg_speed: assert property (($past(nrst) && ctrl_q[`PPC_B_AN_EN])
        |-> (phy_speed_100 == $past(an_speed_100)))
        else $error("negotiated speed not applied");
    a_neg_duplex: assert property (($past(nrst) && ctrl_q[`PPC_B_AN_EN] && !$past(an_failed))
        |-> (phy_full_duplex == $past(an_full_duplex)))
        else $error("negotiated duplex not applied");
    a_ctrl_write_lands: assert property (wr_ctrl |=> (ctrl_q == ($past(wr_data) & `PPC_CTRL_WMASK)))
        else $error("control write not stored");

    // scenarios the bench is expected to reach
    c_blank_write: cover property (wr_ctrl && wr_data[15] ##1 led_pins == 4'hf);
    c_restart_done: cover property (an_restart ##[1:20] an_done);
    c_forced_mode: cover property (!ctrl_q[7] && phy_speed_100 && phy_full_duplex);
    c_an_failed: cover property (ctrl_q[7] && an_failed);
    c_forced_half: cover property (!ctrl_q[7] && !phy_speed_100 && !phy_full_duplex);
endmodule

// File: ppc_port_phy_ctrl_test.sv
// self-checking bench for the port phy control register block
// assumes the design files and the constants header are compiled first
`timescale 1ns/1ps
`include "ppc_regs.svh"
module ppc_port_phy_ctrl_test;
    // clock, reset and bus drive, all given at time zero
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2; // whole words only
    logic [31:0] hwdata = 32'h0;
    logic hready;
    // negotiation results and led patterns
    logic an_done = 1'b1;
    logic an_failed = 1'b0;
    logic an_speed_100 = 1'b0;
    logic an_full_duplex = 1'b0;
    logic [3:0] led_state = 4'h0;
    // design outputs
    logic hreadyout, hresp;
    logic [31:0] hrdata;
    logic led0, led1, led2, led3, tx_disable, phy_power_down, auto_mdix_en, force_mdix;
    logic far_end_loopback, phy_speed_100, phy_full_duplex, an_enable, an_restart;
    logic adv_pause, adv_100_full, adv_100_half, adv_10_full, adv_10_half;
    // bench state
    int num_errors = 0;
    int samples_checked = 0;
    logic [15:0] ctrl_m; // model of the control register
    logic [31:0] rd, d;
    logic [16:0] outs, e;

    // one slave, so its ready is the bus ready
    assign hready = hreadyout;
    // all control outputs but an_restart gathered for one compare
    assign outs = {led3, led2, led1, led0, tx_disable, phy_power_down, auto_mdix_en, force_mdix,
        far_end_loopback, phy_speed_100, phy_full_duplex, an_enable,
        adv_pause, adv_100_full, adv_100_half, adv_10_full, adv_10_half};

    ppc_port_phy_ctrl dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .an_done(an_done), .an_failed(an_failed),
        .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex), .led_state(led_state),
        .second_port_led_out_0(led0), .second_port_led_out_1(led1), .second_port_led_out_2(led2),
        .second_port_led_out_3(led3), .tx_disable(tx_disable), .phy_power_down(phy_power_down),
        .auto_mdix_en(auto_mdix_en), .force_mdix(force_mdix), .far_end_loopback(far_end_loopback),
        .phy_speed_100(phy_speed_100), .phy_full_duplex(phy_full_duplex), .an_enable(an_enable),
        .an_restart(an_restart), .adv_pause(adv_pause), .adv_100_full(adv_100_full),
        .adv_100_half(adv_100_half), .adv_10_full(adv_10_full), .adv_10_half(adv_10_half));

    // 20 mhz clock
    always #25 ref_clk = ~ref_clk;

    // closing report, the single end of the run
    task give_verdict;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // compare and count
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // waits for hready at a rising edge, bounded
    task wait_ready;
        int n;
        n = 0;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                num_errors++;
                $display("wrong value at %0t: bus hang", $time);
                give_verdict;
            end
            @(posedge ref_clk);
        end
    endtask

    // one single transfer; entered and left right after a rising edge
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready;
        q = hrdata;
        check({31'h0, hresp}, 32'h0, "response code");
        // reserved bit 12 is not stored
        if (wr && a == 8'h08) begin
            ctrl_m = wd[15:0] & 16'hefff;
        end
    endtask

    // expected outputs from a control word and the current inputs
    function automatic logic [16:0] exp_outs(input logic [15:0] c);
        logic spd, dup;
        spd = c[7] ? an_speed_100 : c[6];
        dup = (c[7] && !an_failed) ? an_full_duplex : c[5];
        return {(c[15] ? 4'hf : led_state), c[14], c[11], ~c[10], c[10] & c[9], c[8], spd, dup, c[7], c[4:0]};
    endfunction

    // reset values, then release and readback of the default word
    task reset_and_check;
        nrst <= 1'b0;
        repeat (20) @(posedge ref_clk);
        #1 check({15'h0, outs}, 32'h1e43f, "outputs in reset");
        check({30'h0, hreadyout, hresp}, 32'h2, "bus outputs in reset");
        @(posedge ref_clk);
        nrst <= 1'b1;
        ctrl_m = 16'h009f;
        @(posedge ref_clk);
        bus(1'b0, 8'h08, 32'h0, rd);
        check(rd, 32'h0000009f, "control reset value");
        #1 check({15'h0, outs}, {15'h0, exp_outs(ctrl_m)}, "decoded reset word");
        @(posedge ref_clk);
    endtask

    initial begin
        void'($urandom(37));
        reset_and_check;
        // random control words with random negotiation results and leds
        for (int i = 0; i < 64; i++) begin
            led_state <= 4'($urandom);
            {an_failed, an_speed_100, an_full_duplex} <= 3'($urandom);
            @(posedge ref_clk);
            d = $urandom;
            if (i < 2) begin
                d[15:0] = (i == 0) ? 16'hffff : 16'h0000; // all ones and all zeros
            end
            bus(1'b1, 8'h08, d, rd);
            #1 check({15'h0, outs}, {15'h0, exp_outs(ctrl_m)}, "control outputs");
            check({31'h0, an_restart}, {31'h0, d[13] & d[7]}, "restart pulse");
            @(posedge ref_clk);
            #1 check({31'h0, an_restart}, 32'h0, "restart pulse length");
            @(posedge ref_clk);
            bus(1'b0, 8'h08, 32'h0, rd);
            check(rd, {16'h0, ctrl_m}, "control readback");
            bus(1'b0, 8'h0c, 32'h0, rd);
            e = exp_outs(ctrl_m);
            check({28'h0, rd[4:1]}, {28'h0, e[10], e[9], e[6], e[7]}, "status readback");
        end
        // unmapped place: write dropped, read zero, control untouched
        bus(1'b1, 8'h10, 32'hffffffff, rd);
        bus(1'b0, 8'h10, 32'h0, rd);
        check(rd, 32'h0, "unmapped read");
        bus(1'b0, 8'h08, 32'h0, rd);
        check(rd, {16'h0, ctrl_m}, "control after unmapped write");
        // restart stays busy until negotiation reports done
        an_done <= 1'b0;
        an_failed <= 1'b0;
        bus(1'b1, 8'h08, 32'h0000209f, rd);
        #1 check({31'h0, an_restart}, 32'h1, "restart on write");
        @(posedge ref_clk);
        bus(1'b0, 8'h0c, 32'h0, rd);
        check({31'h0, rd[0]}, 32'h1, "restart busy");
        an_done <= 1'b1;
        repeat (3) @(posedge ref_clk);
        bus(1'b0, 8'h0c, 32'h0, rd);
        check({31'h0, rd[0]}, 32'h0, "restart finished");
        // a restart write while still waiting kicks a fresh pulse
        bus(1'b1, 8'h08, 32'h0000209f, rd);
        bus(1'b1, 8'h08, 32'h0000209f, rd);
        #1 check({31'h0, an_restart}, 32'h1, "restart on second write");
        @(posedge ref_clk);
        #1 check({31'h0, an_restart}, 32'h0, "second restart length");
        @(posedge ref_clk);
        // restart write with negotiation off gives no restart pulse
        bus(1'b1, 8'h08, 32'h00002000, rd);
        #1 check({31'h0, an_restart}, 32'h0, "restart while disabled");
        @(posedge ref_clk);
        // second reset in mid-run
        reset_and_check;
        give_verdict;
    end
endmodule

// File: ppc_regs.svh
// register offsets, field positions and reset values of the port phy control block
// assumes inclusion by bare name from any file that needs them
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

// register indices; byte address is four times the index
`define PPC_IDX_CTRL 6'h02
`define PPC_IDX_STAT 6'h03

// control register fields
`define PPC_B_LED_OFF 15
`define PPC_B_TX_DIS 14
`define PPC_B_AN_RESTART 13
`define PPC_B_RSVD 12
`define PPC_B_PWR_DOWN 11
`define PPC_B_MDIX_DIS 10
`define PPC_B_FORCE_MDIX 9
`define PPC_B_FAR_LB 8
`define PPC_B_AN_EN 7
`define PPC_B_SPEED 6
`define PPC_B_DUPLEX 5
`define PPC_B_ADV_PAUSE 4
`define PPC_B_ADV_100F 3
`define PPC_B_ADV_100H 2
`define PPC_B_ADV_10F 1
`define PPC_B_ADV_10H 0

// reset value and writable bits of the control register
`define PPC_CTRL_RST 16'h009f
`define PPC_CTRL_WMASK 16'hefff

// status register fields
`define PPC_S_BUSY 0
`define PPC_S_SPEED 1
`define PPC_S_DUPLEX 2
`define PPC_S_FMDIX 3
`define PPC_S_AMDIX 4

`endif
